// *** hdl/fcds_dma.sv ***
/*
 * Four-channel byte DMA sequencer with its memory-to-memory byte FIFO.
 * Assumes every pin input is asynchronous to core_clk_i and that the
 * surroundings resolve each three-state pin from its value and active-low enable.
 */
`timescale 1ns/1ns
`default_nettype none

module fcds_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q, rp_q;
    logic [AW:0] cnt_q;
    logic push, pop;

    assign in_ready_o = cnt_q != DEPTH[AW:0];
    assign out_valid_o = cnt_q != '0;
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem_q[rp_q];

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wp_q] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= rp_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

module fcds_dma (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [3:0] channel_request_line_i,
    input wire logic hold_acknowledge_i,
    input wire logic ready_i,
    input wire logic end_of_process_line_n_i,
    input wire logic device_select_n_i,
    input wire logic io_read_strobe_n_i,
    input wire logic io_write_strobe_n_i,
    input wire logic [3:0] register_select_lines_i,
    input wire logic [7:0] db_i,
    output logic hold_request_o,
    output logic [3:0] channel_acknowledge_line_o,
    output logic [15:0] addr_o,
    output logic addr_oe_n_o,
    output logic io_read_strobe_n_o,
    output logic io_write_strobe_n_o,
    output logic memory_read_strobe_n_o,
    output logic memory_write_strobe_n_o,
    output logic strobe_oe_n_o,
    output logic [7:0] db_o,
    output logic db_oe_n_o,
    output logic end_of_process_line_n_o,
    output logic end_of_process_line_oe_n_o,
    output logic [3:0] terminal_count_flag_o
);
    logic [fcds_pkg::SYNC_W-1:0] sy1_q, sy2_q;
    logic [1:0] sy3_q;
    logic [3:0] sel1_q, sel2_q;
    logic [3:0] req_s;
    logic hold_acknowledge_s, rdy_s, eop_s, cs_s, rd_s, wr_s, rd_prev, wr_prev;
    logic [7:0] db_s;

    fcds_pkg::fcds_chan_s chan_q [4];
    fcds_pkg::fcds_state_e st_q;
    logic [7:0] cmd_q, db_q, tmp_q, rd_data;
    logic [3:0] mask_q, sreq_q, tc_q, hreq, valid, tc_set, eop_clr;
    logic [1:0] ch_q, mcnt_q, pick, cur_ch;
    logic ptr_q, end_q, eop_q, db_drv_q;
    logic prog, wr_go, rd_go, mclr, tc_hit, term, active, xfer;
    logic fifo_in_rdy, fifo_out_vld;
    logic [7:0] fifo_out;
    logic [3:0] sel;

    function automatic logic [1:0] fcds_prio(input logic [3:0] r);
        fcds_prio = 2'h0;
        for (int i = 3; i >= 0; i--) begin
            if (r[i]) begin
                fcds_prio = i[1:0];
            end
        end
    endfunction

    function automatic logic [15:0] fcds_step(input logic [15:0] a, input logic dec);
        fcds_step = dec ? a - 16'h0001 : a + 16'h0001;
    endfunction

    // pins are asynchronous; the third stage exists only for strobe edges
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            // idle pin levels, so no false request or grant follows reset
            sy1_q <= {4'h0, 1'h0, 5'h1F, 8'h00};
            sy2_q <= {4'h0, 1'h0, 5'h1F, 8'h00};
            sy3_q <= 2'h3;
            sel1_q <= 4'h0;
            sel2_q <= 4'h0;
        end else begin
            sy1_q <= {channel_request_line_i, hold_acknowledge_i, ready_i,
                      end_of_process_line_n_i, device_select_n_i,
                      io_read_strobe_n_i, io_write_strobe_n_i, db_i};
            sy2_q <= sy1_q;
            sy3_q <= sy2_q[9:8];
            // same delay as the strobes, so index and strobe edge line up
            sel1_q <= register_select_lines_i;
            sel2_q <= sel1_q;
        end
    end

    assign req_s = sy2_q[17:14];
    assign hold_acknowledge_s = sy2_q[13];
    assign rdy_s = sy2_q[12];
    assign eop_s = !sy2_q[11];
    assign cs_s = !sy2_q[10];
    assign rd_s = !sy2_q[9];
    assign wr_s = !sy2_q[8];
    assign db_s = sy2_q[7:0];
    assign rd_prev = !sy3_q[1];
    assign wr_prev = !sy3_q[0];
    assign sel = sel2_q;

    // the synchronised acknowledge already implies a clock edge after its fall
    // register access never waits on requests, but it does need a running clock
    assign prog = cs_s && !hold_acknowledge_s &&
                  (st_q == fcds_pkg::ST_IDLE || st_q == fcds_pkg::ST_S0);
    // writes act on the trailing edge so the sampled data has settled
    assign wr_go = prog && !wr_s && wr_prev;
    assign rd_go = prog && rd_s && !rd_prev;
    assign mclr = wr_go && sel == fcds_pkg::OFS_MCLR;

    assign hreq = cmd_q[fcds_pkg::CMD_REQLO] ? ~req_s : req_s;
    assign valid = sreq_q | (hreq & ~mask_q);
    assign pick = fcds_prio(valid);

    assign cur_ch = (st_q == fcds_pkg::ST_S24) ? 2'h1 : ch_q;
    assign tc_hit = chan_q[cur_ch].cur_cnt == 16'h0000;
    assign xfer = st_q == fcds_pkg::ST_S4 || st_q == fcds_pkg::ST_S24;
    assign term = xfer && (tc_hit || end_q || eop_s);
    assign tc_set = (xfer && tc_hit) ? (4'h1 << cur_ch) : 4'h0;
    assign eop_clr = term ? (4'h1 << cur_ch) : 4'h0;

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q <= fcds_pkg::ST_IDLE;
            ch_q <= 2'h0;
        end else if (mclr) begin
            st_q <= fcds_pkg::ST_IDLE;
        end else begin
            case (st_q)
                fcds_pkg::ST_IDLE: begin
                    // a grant left from the last service must drop before a new request
                    if (|valid && !cmd_q[fcds_pkg::CMD_DIS] && !hold_acknowledge_s) begin
                        st_q <= fcds_pkg::ST_S0;
                    end
                end
                fcds_pkg::ST_S0: begin
                    if (hold_acknowledge_s) begin
                        ch_q <= pick;
                        if (valid == 4'h0) begin
                            st_q <= fcds_pkg::ST_IDLE;
                        end else if (chan_q[pick].mode.svc == fcds_pkg::SVC_CASCADE) begin
                            st_q <= fcds_pkg::ST_CASC;
                        end else if (cmd_q[fcds_pkg::CMD_M2M] && pick == 2'h0) begin
                            st_q <= fcds_pkg::ST_S11;
                        end else begin
                            st_q <= fcds_pkg::ST_S1;
                        end
                    end
                end
                fcds_pkg::ST_CASC: begin
                    if (!valid[ch_q]) begin
                        st_q <= fcds_pkg::ST_IDLE;
                    end
                end
                fcds_pkg::ST_S1: st_q <= fcds_pkg::ST_S2;
                fcds_pkg::ST_S2: st_q <= fcds_pkg::ST_S3;
                fcds_pkg::ST_S3, fcds_pkg::ST_WAIT_STATE: begin
                    // verify moves nothing, so it never waits
                    if (rdy_s || chan_q[ch_q].mode.xtype == fcds_pkg::XT_VERIFY) begin
                        st_q <= fcds_pkg::ST_S4;
                    end else begin
                        st_q <= fcds_pkg::ST_WAIT_STATE;
                    end
                end
                fcds_pkg::ST_S4: begin
                    if (term || chan_q[ch_q].mode.svc == fcds_pkg::SVC_SINGLE) begin
                        st_q <= fcds_pkg::ST_IDLE;
                    end else if (chan_q[ch_q].mode.svc == fcds_pkg::SVC_DEMAND &&
                                 !hreq[ch_q] && !sreq_q[ch_q]) begin
                        st_q <= fcds_pkg::ST_IDLE;
                    end else begin
                        st_q <= fcds_pkg::ST_S2;
                    end
                end
                fcds_pkg::ST_S11: st_q <= fcds_pkg::ST_S12;
                fcds_pkg::ST_S12: st_q <= fcds_pkg::ST_S13;
                fcds_pkg::ST_S13: st_q <= fcds_pkg::ST_S14;
                fcds_pkg::ST_S14: st_q <= fcds_pkg::ST_S21;
                fcds_pkg::ST_S21: begin
                    // the read byte reaches the sampled bus here; full buffer stalls
                    if (fifo_in_rdy) begin
                        st_q <= fcds_pkg::ST_S22;
                    end
                end
                fcds_pkg::ST_S22: begin
                    if (fifo_out_vld) begin
                        st_q <= fcds_pkg::ST_S23;
                    end
                end
                fcds_pkg::ST_S23: st_q <= fcds_pkg::ST_S24;
                fcds_pkg::ST_S24: st_q <= term ? fcds_pkg::ST_IDLE : fcds_pkg::ST_S11;
                default: st_q <= fcds_pkg::ST_IDLE;
            endcase
        end
    end

    // external end of process is held until the transfer it belongs to ends
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            end_q <= 1'b0;
            eop_q <= 1'b0;
        end else begin
            eop_q <= xfer && tc_hit;
            if (st_q == fcds_pkg::ST_S0 || st_q == fcds_pkg::ST_IDLE) begin
                end_q <= 1'b0;
            end else if (eop_s && active) begin
                end_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < 4; i++) begin
                chan_q[i] <= '0;
            end
        end else begin
            if (wr_go && !sel[3]) begin
                if (!sel[0]) begin
                    if (ptr_q) begin
                        chan_q[sel[2:1]].base_addr[15:8] <= db_s;
                        chan_q[sel[2:1]].cur_addr[15:8] <= db_s;
                    end else begin
                        chan_q[sel[2:1]].base_addr[7:0] <= db_s;
                        chan_q[sel[2:1]].cur_addr[7:0] <= db_s;
                    end
                end else begin
                    if (ptr_q) begin
                        chan_q[sel[2:1]].base_cnt[15:8] <= db_s;
                        chan_q[sel[2:1]].cur_cnt[15:8] <= db_s;
                    end else begin
                        chan_q[sel[2:1]].base_cnt[7:0] <= db_s;
                        chan_q[sel[2:1]].cur_cnt[7:0] <= db_s;
                    end
                end
            end
            if (wr_go && sel == fcds_pkg::OFS_MODE) begin
                chan_q[db_s[1:0]].mode <= fcds_pkg::fcds_mode_s'(db_s[7:2]);
            end
            if (xfer) begin
                chan_q[cur_ch].cur_addr <= fcds_step(chan_q[cur_ch].cur_addr,
                                                     chan_q[cur_ch].mode.dec);
                chan_q[cur_ch].cur_cnt <= chan_q[cur_ch].cur_cnt - 16'h0001;
                if (term && chan_q[cur_ch].mode.auto_init) begin
                    chan_q[cur_ch].cur_addr <= chan_q[cur_ch].base_addr;
                    chan_q[cur_ch].cur_cnt <= chan_q[cur_ch].base_cnt;
                end
            end
            // the source channel rolls over silently and only reloads
            if (st_q == fcds_pkg::ST_S14) begin
                if (!cmd_q[fcds_pkg::CMD_HOLD0]) begin
                    chan_q[0].cur_addr <= fcds_step(chan_q[0].cur_addr, chan_q[0].mode.dec);
                end
                chan_q[0].cur_cnt <= chan_q[0].cur_cnt - 16'h0001;
                if (chan_q[0].cur_cnt == 16'h0000 && chan_q[0].mode.auto_init) begin
                    chan_q[0].cur_addr <= chan_q[0].base_addr;
                    chan_q[0].cur_cnt <= chan_q[0].base_cnt;
                end
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cmd_q <= fcds_pkg::CMD_RST;
            mask_q <= fcds_pkg::MASK_RST;
            sreq_q <= 4'h0;
            tc_q <= 4'h0;
            ptr_q <= 1'b0;
            mcnt_q <= 2'h0;
        end else if (mclr) begin
            cmd_q <= fcds_pkg::CMD_RST;
            mask_q <= fcds_pkg::MASK_RST;
            sreq_q <= 4'h0;
            tc_q <= tc_set;
            ptr_q <= 1'b0;
            mcnt_q <= 2'h0;
        end else begin
            if (wr_go && sel == fcds_pkg::OFS_CMD) begin
                cmd_q <= db_s;
            end
            // a flag set in the cycle of a status read survives the read
            tc_q <= ((rd_go && sel == fcds_pkg::OFS_CMD) ? 4'h0 : tc_q) | tc_set;
            if (wr_go && sel == fcds_pkg::OFS_REQ) begin
                sreq_q <= (sreq_q & ~(4'h1 << db_s[1:0]) & ~eop_clr) |
                          ({3'h0, db_s[fcds_pkg::SEL_BIT]} << db_s[1:0]);
            end else begin
                sreq_q <= sreq_q & ~eop_clr;
            end
            if (wr_go && sel == fcds_pkg::OFS_SMASK) begin
                mask_q[db_s[1:0]] <= db_s[fcds_pkg::SEL_BIT];
            end else if (wr_go && sel == fcds_pkg::OFS_AMASK) begin
                mask_q <= db_s[3:0];
            end else if (wr_go && sel == fcds_pkg::OFS_CMASK) begin
                mask_q <= 4'h0;
            end else if (term && !chan_q[cur_ch].mode.auto_init) begin
                mask_q[cur_ch] <= 1'b1;
            end
            if ((wr_go || rd_go) && !sel[3]) begin
                ptr_q <= !ptr_q;
            end else if (wr_go && sel == fcds_pkg::OFS_PTR) begin
                ptr_q <= 1'b0;
            end else if (rd_go && sel == fcds_pkg::OFS_PTR) begin
                ptr_q <= 1'b1;
            end
            if (rd_go && sel == fcds_pkg::OFS_CMASK) begin
                mcnt_q <= 2'h0;
            end else if (rd_go && sel == fcds_pkg::OFS_MODE) begin
                mcnt_q <= mcnt_q + 2'h1;
            end
        end
    end

    always_comb begin
        logic [15:0] w;
        w = sel[0] ? chan_q[sel[2:1]].cur_cnt : chan_q[sel[2:1]].cur_addr;
        rd_data = 8'h00;
        if (!sel[3]) begin
            rd_data = ptr_q ? w[15:8] : w[7:0];
        end else begin
            case (sel)
                fcds_pkg::OFS_CMD: rd_data = {hreq, tc_q};
                fcds_pkg::OFS_MODE: rd_data = {chan_q[mcnt_q].mode, mcnt_q};
                fcds_pkg::OFS_MCLR: rd_data = tmp_q;
                default: rd_data = 8'h00;
            endcase
        end
    end

    fcds_fifo #(
        .WIDTH(fcds_pkg::FIFO_W),
        .DEPTH(fcds_pkg::FIFO_D)
    ) u_fifo (
        .clk_i(core_clk_i),
        .rst_i(rst_i),
        .in_valid_i(st_q == fcds_pkg::ST_S21),
        .in_ready_o(fifo_in_rdy),
        .in_data_i(db_s),
        .out_valid_o(fifo_out_vld),
        .out_ready_i(st_q == fcds_pkg::ST_S22),
        .out_data_o(fifo_out)
    );

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            db_q <= 8'h00;
            tmp_q <= 8'h00;
            db_drv_q <= 1'b0;
        end else begin
            if (st_q == fcds_pkg::ST_S22 && fifo_out_vld) begin
                db_q <= fifo_out;
                tmp_q <= fifo_out;
            end else if (rd_go) begin
                db_q <= rd_data;
            end
            db_drv_q <= (prog && rd_s) || st_q == fcds_pkg::ST_S23 ||
                        (st_q == fcds_pkg::ST_S22 && fifo_out_vld);
        end
    end

    // cascade, idle and the first service state leave the shared buses alone
    assign active = !(st_q == fcds_pkg::ST_IDLE || st_q == fcds_pkg::ST_S0 ||
                      st_q == fcds_pkg::ST_CASC);

    always_comb begin
        logic rd_ph, m2m;
        logic [3:0] ack;
        rd_ph = st_q == fcds_pkg::ST_S3 || st_q == fcds_pkg::ST_WAIT_STATE ||
                st_q == fcds_pkg::ST_S4;
        m2m = st_q >= fcds_pkg::ST_S11 && st_q <= fcds_pkg::ST_S24;
        ack = ((st_q >= fcds_pkg::ST_S1 && st_q <= fcds_pkg::ST_WAIT_STATE) ||
               st_q == fcds_pkg::ST_CASC) ? (4'h1 << ch_q) : 4'h0;
        // both halves fire in one window; the byte moves between the peers
        io_read_strobe_n_o = !(rd_ph && chan_q[ch_q].mode.xtype == fcds_pkg::XT_WRITE);
        memory_write_strobe_n_o = !((rd_ph && chan_q[ch_q].mode.xtype == fcds_pkg::XT_WRITE) ||
                                    st_q == fcds_pkg::ST_S23 || st_q == fcds_pkg::ST_S24);
        memory_read_strobe_n_o = !((rd_ph && chan_q[ch_q].mode.xtype == fcds_pkg::XT_READ) ||
                                   st_q == fcds_pkg::ST_S13 || st_q == fcds_pkg::ST_S14);
        io_write_strobe_n_o = !(rd_ph && chan_q[ch_q].mode.xtype == fcds_pkg::XT_READ);
        addr_o = m2m ? chan_q[(st_q >= fcds_pkg::ST_S21) ? 2'h1 : 2'h0].cur_addr
                     : chan_q[ch_q].cur_addr;
        channel_acknowledge_line_o = cmd_q[fcds_pkg::CMD_ACKHI] ? ack : ~ack;
    end

    assign hold_request_o = st_q != fcds_pkg::ST_IDLE;
    assign addr_oe_n_o = !active;
    assign strobe_oe_n_o = !active;
    assign db_o = db_q;
    assign db_oe_n_o = !db_drv_q;
    assign end_of_process_line_n_o = 1'b0;
    assign end_of_process_line_oe_n_o = !eop_q;
    assign terminal_count_flag_o = tc_q;
endmodule

`default_nettype wire

// *** hdl/fcds_pkg.sv ***
/*
 * Constants, types and state codes for the four-channel byte DMA sequencer.
 * Assumes a single 100 MHz core clock; the includer uses every name scoped.
 */
package fcds_pkg;
    localparam int SYNC_W = 18;
    localparam int FIFO_W = 8;
    localparam int FIFO_D = 8;
    localparam logic [3:0] OFS_CMD = 4'h8;
    localparam logic [3:0] OFS_REQ = 4'h9;
    localparam logic [3:0] OFS_SMASK = 4'hA;
    localparam logic [3:0] OFS_MODE = 4'hB;
    localparam logic [3:0] OFS_PTR = 4'hC;
    localparam logic [3:0] OFS_MCLR = 4'hD;
    localparam logic [3:0] OFS_CMASK = 4'hE;
    localparam logic [3:0] OFS_AMASK = 4'hF;
    localparam int CMD_M2M = 0;
    localparam int CMD_HOLD0 = 1;
    localparam int CMD_DIS = 2;
    localparam int CMD_REQLO = 6;
    localparam int CMD_ACKHI = 7;
    localparam int SEL_BIT = 2;
    localparam logic [7:0] CMD_RST = 8'h00;
    localparam logic [3:0] MASK_RST = 4'hF;
    typedef enum logic [1:0] {
        SVC_DEMAND = 2'h0,
        SVC_SINGLE = 2'h1,
        SVC_BLOCK = 2'h2,
        SVC_CASCADE = 2'h3
    } fcds_svc_e;
    typedef enum logic [1:0] {
        XT_VERIFY = 2'h0,
        XT_WRITE = 2'h1,
        XT_READ = 2'h2,
        XT_RSVD = 2'h3
    } fcds_xt_e;
    typedef struct packed {
        fcds_svc_e svc;
        logic dec;
        logic auto_init;
        fcds_xt_e xtype;
    } fcds_mode_s;
    typedef struct packed {
        logic [15:0] base_addr;
        logic [15:0] cur_addr;
        logic [15:0] base_cnt;
        logic [15:0] cur_cnt;
        fcds_mode_s mode;
    } fcds_chan_s;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_S0 = 4'h1,
        ST_S1 = 4'h2,
        ST_S2 = 4'h3,
        ST_S3 = 4'h4,
        ST_S4 = 4'h5,
        ST_WAIT_STATE = 4'h6,
        ST_S11 = 4'h7,
        ST_S12 = 4'h8,
        ST_S13 = 4'h9,
        ST_S14 = 4'hA,
        ST_S21 = 4'hB,
        ST_S22 = 4'hC,
        ST_S23 = 4'hD,
        ST_S24 = 4'hE,
        ST_CASC = 4'hF
    } fcds_state_e;
endpackage

// *** tb/fcds_dma_assertions.sv ***
/* Port checker for fcds_dma.
   Assumes it is bound to every fcds_dma instance. */
`timescale 1ns/1ns
`default_nettype none
module fcds_dma_assertions (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic hold_request_o,
    input wire logic hold_acknowledge_i,
    input wire logic addr_oe_n_o,
    input wire logic strobe_oe_n_o,
    input wire logic io_read_strobe_n_o,
    input wire logic memory_write_strobe_n_o,
    input wire logic [3:0] channel_acknowledge_line_o,
    input wire logic end_of_process_line_oe_n_o,
    input wire logic [3:0] terminal_count_flag_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);
    chk_idle_float: assert property (!hold_request_o |-> addr_oe_n_o && strobe_oe_n_o)
        else $error("bus driven while idle");
    chk_strobe_pair: assert property (!strobe_oe_n_o && !io_read_strobe_n_o
        |-> !memory_write_strobe_n_o) else $error("io read without memory write");
    chk_grant_first: assert property (!hold_acknowledge_i [*4] |-> addr_oe_n_o)
        else $error("address driven without grant");
    chk_drive_held: assert property (!addr_oe_n_o |-> hold_request_o)
        else $error("address driven without hold request");
    chk_eop_pulse: assert property ($fell(end_of_process_line_oe_n_o)
        |=> end_of_process_line_oe_n_o) else $error("end pulse too long");
    chk_eop_flag: assert property ($fell(end_of_process_line_oe_n_o)
        |-> ##[0:1] terminal_count_flag_o != 4'h0) else $error("end pulse without flag");
    chk_ack_quiet: assert property (!hold_request_o
        |-> channel_acknowledge_line_o inside {4'h0, 4'hF}) else $error("ack while idle");
    chk_ack_single: assert property ($onehot0(channel_acknowledge_line_o)
        || $onehot0(~channel_acknowledge_line_o)) else $error("two acks active");
endmodule
bind fcds_dma fcds_dma_assertions u_chk (.core_clk_i, .rst_i, .hold_request_o,
    .hold_acknowledge_i, .addr_oe_n_o, .strobe_oe_n_o, .io_read_strobe_n_o,
    .memory_write_strobe_n_o, .channel_acknowledge_line_o, .end_of_process_line_oe_n_o,
    .terminal_count_flag_o);
`default_nettype wire

// *** tb/fcds_host_model.sv ***
/* Host bus model: grants hold and drives ready.
   Assumes one clock shared with the sequencer. */
`timescale 1ns/1ns
`default_nettype none
module fcds_host_model (
    input wire logic clk_i,
    input wire logic hold_request_i,
    input wire logic slow_i,
    output logic hold_acknowledge_o,
    output logic ready_o
);
    logic [1:0] dly_q = 2'h0;
    assign ready_o = !slow_i;
    // grant late on purpose, withdraw at once so programming reopens
    always @(posedge clk_i) begin
        dly_q <= {dly_q[0], hold_request_i};
        hold_acknowledge_o <= hold_request_i && dly_q[1];
    end
endmodule
`default_nettype wire

// *** tb/test_fcds_dma.sv ***
/* Testbench for fcds_dma: register port and single, block transfers.
   Assumes the bound checker and the host model. */
`timescale 1ns/1ns
`default_nettype none
module test_fcds_dma;
    logic core_clk_i, rst_i, hold_acknowledge_i, ready_i, slow, prev_q, hold_request_o;
    logic device_select_n_i, io_read_strobe_n_i, io_write_strobe_n_i, eop_n;
    logic io_read_strobe_n_o, io_write_strobe_n_o;
    logic [3:0] channel_request_line_i, register_select_lines_i;
    logic [3:0] channel_acknowledge_line_o, terminal_count_flag_o;
    logic [7:0] db_i, db_o, got, n_xfer, n_hold;
    int n_errors = 0;
    int comparisons = 0;
    fcds_dma dut (.core_clk_i, .rst_i, .channel_request_line_i, .hold_acknowledge_i, .ready_i,
        .end_of_process_line_n_i(eop_n), .device_select_n_i, .io_read_strobe_n_i,
        .io_write_strobe_n_i, .register_select_lines_i, .db_i, .hold_request_o,
        .channel_acknowledge_line_o, .addr_o(), .addr_oe_n_o(), .io_read_strobe_n_o,
        .io_write_strobe_n_o, .memory_read_strobe_n_o(), .memory_write_strobe_n_o(),
        .strobe_oe_n_o(), .db_o, .db_oe_n_o(), .end_of_process_line_n_o(),
        .end_of_process_line_oe_n_o(), .terminal_count_flag_o);
    fcds_host_model host (.clk_i(core_clk_i), .hold_request_i(hold_request_o),
        .slow_i(slow), .hold_acknowledge_o(hold_acknowledge_i), .ready_o(ready_i));
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    always @(posedge hold_request_o) n_hold = n_hold + 8'h01;
    always @(negedge core_clk_i) begin
        if (!prev_q && !(io_read_strobe_n_o && io_write_strobe_n_o)) n_xfer = n_xfer + 8'h01;
        prev_q = !(io_read_strobe_n_o && io_write_strobe_n_o);
    end
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        comparisons++;
        if (s !== e) begin
            n_errors++;
            $display("BAD %0t seen %h want %h", $time, s, e);
        end
    endtask
    task automatic results;
        if (n_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // strobes held four clocks each way to clear the input synchronisers
    task automatic acc(input logic [3:0] a, input logic [7:0] d, input logic rd);
        @(negedge core_clk_i);
        device_select_n_i = 1'b0;
        register_select_lines_i = a;
        db_i = d;
        io_read_strobe_n_i = !rd;
        io_write_strobe_n_i = rd;
        repeat (4) @(negedge core_clk_i);
        got = db_o;
        io_read_strobe_n_i = 1'b1;
        io_write_strobe_n_i = 1'b1;
        repeat (4) @(negedge core_clk_i);
        device_select_n_i = 1'b1;
    endtask
    task automatic prog(input logic [1:0] ch, input logic [15:0] a, input logic [15:0] n,
        input logic [7:0] m);
        acc(4'hC, 8'h00, 1'b0);
        acc({1'b0, ch, 1'b0}, a[7:0], 1'b0);
        acc({1'b0, ch, 1'b0}, a[15:8], 1'b0);
        acc({1'b0, ch, 1'b1}, n[7:0], 1'b0);
        acc({1'b0, ch, 1'b1}, n[15:8], 1'b0);
        acc(4'hB, m, 1'b0);
        acc(4'hA, {6'h00, ch}, 1'b0);
    endtask
    initial begin
        #200000;
        n_errors++;
        results;
    end
    initial begin
        {rst_i, eop_n, device_select_n_i, io_read_strobe_n_i, io_write_strobe_n_i} = 5'h1F;
        {channel_request_line_i, register_select_lines_i, db_i, slow} = 17'h00000;
        {n_xfer, n_hold, prev_q} = 17'h00000;
        repeat (5) @(negedge core_clk_i);
        rst_i = 1'b0;
        repeat (2) @(negedge core_clk_i);
        chk({4'h0, channel_acknowledge_line_o}, 8'h0F);
        chk({7'h00, hold_request_o}, 8'h00);
        prog(2'h2, 16'h12FF, 16'h0001, 8'h46);
        channel_request_line_i[2] = 1'b1;
        for (int i = 0; i < 500 && terminal_count_flag_o[2] !== 1'b1; i++) @(negedge core_clk_i);
        repeat (20) @(negedge core_clk_i);
        chk(n_xfer, 8'h02);
        chk(n_hold, 8'h02);
        chk({7'h00, hold_request_o}, 8'h00);
        chk({4'h0, terminal_count_flag_o}, 8'h04);
        channel_request_line_i[2] = 1'b0;
        acc(4'h4, 8'h00, 1'b1);
        chk(got, 8'h01);
        acc(4'h4, 8'h00, 1'b1);
        chk(got, 8'h13);
        acc(4'h5, 8'h00, 1'b1);
        chk(got, 8'hFF);
        {n_xfer, n_hold, slow} = 17'h00001;
        prog(2'h0, 16'h0010, 16'h0002, 8'hA8);
        channel_request_line_i[0] = 1'b1;
        for (int i = 0; i < 100 && channel_acknowledge_line_o === 4'hF; i++) @(negedge core_clk_i);
        channel_request_line_i[0] = 1'b0;
        for (int i = 0; i < 50 && io_write_strobe_n_o !== 1'b0; i++) @(negedge core_clk_i);
        repeat (10) @(negedge core_clk_i);
        chk({7'h00, io_write_strobe_n_o}, 8'h00);
        slow = 1'b0;
        for (int i = 0; i < 500 && terminal_count_flag_o[0] !== 1'b1; i++) @(negedge core_clk_i);
        repeat (5) @(negedge core_clk_i);
        chk(n_xfer, 8'h03);
        chk(n_hold, 8'h01);
        acc(4'h0, 8'h00, 1'b1);
        chk(got, 8'h0D);
        acc(4'hD, 8'h00, 1'b0);
        chk({4'h0, terminal_count_flag_o}, 8'h00);
        prog(2'h1, 16'h0100, 16'h00FF, 8'h89);
        channel_request_line_i[1] = 1'b1;
        for (int i = 0; i < 100 && channel_acknowledge_line_o === 4'hF; i++) @(negedge core_clk_i);
        channel_request_line_i[1] = 1'b0;
        repeat (3) @(negedge core_clk_i);
        chk({7'h00, hold_request_o}, 8'h01);
        eop_n = 1'b0;
        repeat (20) @(negedge core_clk_i);
        eop_n = 1'b1;
        chk({7'h00, hold_request_o}, 8'h00);
        chk({4'h0, terminal_count_flag_o}, 8'h00);
        channel_request_line_i[1] = 1'b1;
        repeat (20) @(negedge core_clk_i);
        chk({7'h00, hold_request_o}, 8'h00);
        results;
    end
endmodule
`default_nettype wire
